// ===== hdl/option_cfg_pkg.sv
// Purpose: shared constants for the option byte configuration decoder
// Assumes: byte-wide option row, addresses in the 16-bit data space
// Notes: none
package option_cfg_pkg;
  // ****************************************
  // option row addresses
  // ****************************************
  localparam logic [15:0] READOUT_GUARD_BYTE_ADDR = 16'h4800;
  localparam logic [15:0] BOOT_AREA_SIZE_BYTE_ADDR = 16'h4802;
  localparam logic [15:0] DATA_AREA_SIZE_BYTE_ADDR = 16'h4803;
  localparam logic [15:0] READ_ACCESS_GUARD_BYTE_ADDR = 16'h4807;
  localparam logic [15:0] WATCHDOG_OPTION_BYTE_ADDR = 16'h4808;
  localparam logic [15:0] OPTION_ROW_BASE = 16'h4800;
  localparam int OPTION_ROW_WORDS = 16;
  localparam int OPTION_IDX_W = 4;
  // ****************************************
  // values and fields
  // ****************************************
  localparam logic [7:0] OPTION_RESET_VALUE = 8'h00;
  localparam logic [7:0] READOUT_GUARD_ON = 8'hAA;
  localparam logic [7:0] READ_ACCESS_GUARD_OK = 8'h00;
  localparam logic [7:0] BOOT_AREA_NONE = 8'h00;
  localparam logic [7:0] BOOT_AREA_VECT_MAX = 8'h02;
  localparam logic [7:0] BOOT_AREA_PAGE_MASK = 8'h7F;
  localparam logic [7:0] DATA_AREA_PAGE_MASK = 8'h3F;
  localparam int WATCHDOG_AUTOSTART_BIT = 0;
  localparam int WATCHDOG_FREEZE_BIT = 1;
  localparam logic [15:0] DATA_AREA_TOP = 16'h9FFF;
  localparam logic [15:0] DATA_AREA_END_PLUS1 = 16'hA000;
  localparam int PAGE_SHIFT = 6;
  // ****************************************
  // loader timing
  // ****************************************
  localparam logic [4:0] LOAD_LAST_INDEX = 5'h0F;
  typedef enum logic [2:0] {
    LOAD_IDLE = 3'b001,
    LOAD_SCAN = 3'b010,
    LOAD_DONE = 3'b100
  } load_state_t;
endpackage

// ===== hdl/option_row_mem.sv
// Purpose: small option byte row storage with registered read data
// Assumes: one write port and one read port, write has priority over nothing (separate ports)
// Notes: contents persist across resets, as non-volatile storage would
`timescale 1ns/1ps
module option_row_mem
  import option_cfg_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic wr_en_i,
  input wire logic [OPTION_IDX_W-1:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [OPTION_IDX_W-1:0] rd_idx_i,
  output logic [7:0] rd_data_o
);
  // initial contents are the factory setting; read data is unknown until the first edge
  logic [7:0] mem_reg [OPTION_ROW_WORDS] = '{default: OPTION_RESET_VALUE};

  // ****************************************
  // storage and registered read
  // ****************************************
  // one process owns both the array and the read register
  always_ff @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      mem_reg[wr_idx_i] <= wr_data_i;
    end
    rd_data_o <= mem_reg[rd_idx_i];
  end
endmodule

// ===== hdl/option_byte_config_decoder.sv
// Purpose: hold the option byte row and decode it into device configuration
// Assumes: option writes arrive over the debug link port on clk_sys_i
// Notes: decoded outputs refresh only by the scan after each reset
//   a row write that races the scan may or may not be seen by it
//   the cpu port has no data path; it only reports refused row writes
`timescale 1ns/1ps
module option_byte_config_decoder
  import option_cfg_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic in_circuit_programming_i,
  input wire logic link_wr_i,
  input wire logic [15:0] link_addr_i,
  input wire logic [7:0] link_wdata_i,
  input wire logic cpu_wr_i,
  input wire logic [15:0] cpu_addr_i,
  output logic cpu_wr_refused_o,
  output logic config_valid_o,
  output logic readout_guard_o,
  output logic [7:0] boot_area_pages_o,
  output logic boot_area_protect_o,
  output logic [7:0] boot_vector_pages_o,
  output logic [7:0] data_area_pages_o,
  output logic [15:0] data_area_base_o,
  output logic data_area_present_o,
  output logic watchdog_autostart_o,
  output logic watchdog_lowpower_freeze_o,
  output logic read_access_unsure_o
);
  // ****************************************
  // helpers
  // ****************************************
  // true for any byte address inside the 16-byte option row
  function automatic logic in_row(input logic [15:0] addr);
    in_row = (addr >= OPTION_ROW_BASE) &&
             (addr < OPTION_ROW_BASE + 16'(OPTION_ROW_WORDS));
  endfunction

  // low address bits pick the byte inside the row
  function automatic logic [OPTION_IDX_W-1:0] row_idx(input logic [15:0] addr);
    logic [15:0] off;
    off = addr - OPTION_ROW_BASE;
    row_idx = off[OPTION_IDX_W-1:0];
  endfunction

  // ****************************************
  // write path
  // ****************************************
  // programming mode is a pin level from another domain, so synchronise it
  logic mode_meta_reg;
  logic mode_sync_reg;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      mode_meta_reg <= 1'b0;
      mode_sync_reg <= 1'b0;
    end else begin
      mode_meta_reg <= in_circuit_programming_i;
      mode_sync_reg <= mode_meta_reg;
    end
  end

  // a link write lands only while the synchronised mode is high
  wire link_hit = link_wr_i && in_row(link_addr_i);
  wire mem_wr_en = link_hit && mode_sync_reg;
  // the cpu path never writes the row; flag the attempt instead
  wire cpu_hit = cpu_wr_i && in_row(cpu_addr_i);
  wire link_refused = link_hit && !mode_sync_reg;

  logic cpu_wr_refused_reg;
  // one-cycle pulse for every refused row write
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cpu_wr_refused_reg <= 1'b0;
    end else begin
      cpu_wr_refused_reg <= cpu_hit || link_refused;
    end
  end
  assign cpu_wr_refused_o = cpu_wr_refused_reg;

  // ****************************************
  // load sequencer
  // ****************************************
  load_state_t state_reg;
  load_state_t state_next;
  logic [4:0] scan_reg;
  logic [4:0] scan_next;
  logic [OPTION_IDX_W-1:0] rd_idx;
  logic [7:0] rd_data;
  // read data lag the index by one cycle, so capture the previous index
  logic [4:0] cap_idx_reg;
  logic cap_en_reg;

  option_row_mem u_mem (
    .clk_sys_i(clk_sys_i),
    .wr_en_i(mem_wr_en),
    .wr_idx_i(row_idx(link_addr_i)),
    .wr_data_i(link_wdata_i),
    .rd_idx_i(rd_idx),
    .rd_data_o(rd_data)
  );

  // the scan index addresses the row directly
  assign rd_idx = scan_reg[OPTION_IDX_W-1:0];

  // one pass over the row after reset, then stay done
  always_comb begin
    state_next = state_reg;
    scan_next = scan_reg;
    unique case (state_reg)
      LOAD_IDLE: begin
        state_next = LOAD_SCAN;
        scan_next = 5'h00;
      end
      LOAD_SCAN: begin
        if (scan_reg == LOAD_LAST_INDEX) begin
          state_next = LOAD_DONE;
        end else begin
          scan_next = scan_reg + 5'h01;
        end
      end
      LOAD_DONE: begin
        state_next = LOAD_DONE;
      end
      default: begin
        state_next = LOAD_IDLE;
      end
    endcase
  end

  // state, scan index and the index whose byte arrives next cycle
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= LOAD_IDLE;
      scan_reg <= 5'h00;
      cap_idx_reg <= 5'h00;
      cap_en_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      scan_reg <= scan_next;
      cap_idx_reg <= scan_reg;
      cap_en_reg <= (state_reg == LOAD_SCAN);
    end
  end

  // ****************************************
  // captured option bytes, size bytes masked
  // ****************************************
  logic [7:0] guard_reg;
  logic [7:0] boot_reg;
  logic [7:0] data_reg;
  logic [7:0] access_reg;
  logic [7:0] wdog_reg;
  logic valid_reg;
  wire [15:0] cap_addr = OPTION_ROW_BASE + {11'h000, cap_idx_reg};
  // capture strobes decoded from the lagged index, one per stored byte
  wire cap_guard = cap_en_reg && (cap_addr == READOUT_GUARD_BYTE_ADDR);
  wire cap_boot = cap_en_reg && (cap_addr == BOOT_AREA_SIZE_BYTE_ADDR);
  wire cap_data = cap_en_reg && (cap_addr == DATA_AREA_SIZE_BYTE_ADDR);
  wire cap_access = cap_en_reg && (cap_addr == READ_ACCESS_GUARD_BYTE_ADDR);
  wire cap_wdog = cap_en_reg && (cap_addr == WATCHDOG_OPTION_BYTE_ADDR);
  wire cap_last = cap_en_reg && (cap_idx_reg == LOAD_LAST_INDEX);
  // stored top bits are ignored, so masking at capture keeps every consumer clean
  wire [7:0] boot_masked = rd_data & BOOT_AREA_PAGE_MASK;
  wire [7:0] data_masked = rd_data & DATA_AREA_PAGE_MASK;

  // only the scan writes these, so mid-run programming cannot disturb them
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      guard_reg <= OPTION_RESET_VALUE;
      boot_reg <= OPTION_RESET_VALUE;
      data_reg <= OPTION_RESET_VALUE;
      access_reg <= OPTION_RESET_VALUE;
      wdog_reg <= OPTION_RESET_VALUE;
      valid_reg <= 1'b0;
    end else begin
      if (cap_guard) guard_reg <= rd_data;
      if (cap_boot) boot_reg <= boot_masked;
      if (cap_data) data_reg <= data_masked;
      if (cap_access) access_reg <= rd_data;
      if (cap_wdog) wdog_reg <= rd_data;
      // valid stays up until the next reset clears it
      if (cap_last) valid_reg <= 1'b1;
    end
  end

  // ****************************************
  // decode
  // ****************************************
  wire boot_none = (boot_reg == BOOT_AREA_NONE);
  wire boot_vect_only = !boot_none && (boot_reg <= BOOT_AREA_VECT_MAX);
  // each data page is 64 bytes and the area grows down from the top
  wire [15:0] data_span = {2'h0, data_reg, 6'h00};
  wire [15:0] data_base = DATA_AREA_END_PLUS1 - data_span;

  assign config_valid_o = valid_reg;
  assign readout_guard_o = (guard_reg == READOUT_GUARD_ON);
  assign boot_area_pages_o = boot_reg;
  // pages 0..value-1 are protected; vector-only sizes still protect vectors
  assign boot_area_protect_o = !boot_none;
  assign boot_vector_pages_o = boot_none ? 8'h00 : (boot_vect_only ? boot_reg : BOOT_AREA_VECT_MAX);
  assign data_area_pages_o = data_reg;
  assign data_area_present_o = (data_reg != 8'h00);
  assign data_area_base_o = (data_reg == 8'h00) ? DATA_AREA_END_PLUS1 : data_base;
  assign watchdog_autostart_o = wdog_reg[WATCHDOG_AUTOSTART_BIT];
  assign watchdog_lowpower_freeze_o = wdog_reg[WATCHDOG_FREEZE_BIT];
  // the device depends on the programmer leaving this byte at zero
  assign read_access_unsure_o = (access_reg != READ_ACCESS_GUARD_OK);
endmodule

// ===== test/option_link_programmer.sv
// Purpose: behavioural in-circuit programmer on the debug link write port
// Assumes: one byte per strobe, mode pin set well before writing
// Notes: idle lines show the inverse of the last value, never a held copy
`timescale 1ns/1ps
module option_link_programmer
  import option_cfg_pkg::*;
(
  input wire logic clk_sys_i,
  output logic mode_o,
  output logic link_wr_o,
  output logic [15:0] link_addr_o,
  output logic [7:0] link_wdata_o
);
  // quiet start: mode off, no strobe
  initial begin
    mode_o = 1'b0;
    link_wr_o = 1'b0;
    link_addr_o = 16'hFFFF;
    link_wdata_o = 8'hFF;
  end
  // the device synchronises the pin, so wait past two edges
  task automatic set_mode(input logic on);
    @(posedge clk_sys_i);
    mode_o <= on;
    repeat (3) @(posedge clk_sys_i);
  endtask
  // one byte write on the link
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    link_wr_o <= 1'b1;
    link_addr_o <= a;
    link_wdata_o <= d;
    @(posedge clk_sys_i);
    link_wr_o <= 1'b0;
    link_addr_o <= ~a;
    link_wdata_o <= ~d;
  endtask
  // the five decoded bytes of the row; u is zero unless a scenario asks otherwise
  task automatic row(input logic [7:0] g, b, d, w, u);
    put(READOUT_GUARD_BYTE_ADDR, g);
    put(BOOT_AREA_SIZE_BYTE_ADDR, b);
    put(DATA_AREA_SIZE_BYTE_ADDR, d);
    put(READ_ACCESS_GUARD_BYTE_ADDR, u);
    put(WATCHDOG_OPTION_BYTE_ADDR, w);
  endtask
endmodule

// ===== test/option_byte_config_decoder_sva.sv
// Purpose: port checks of the option byte decoder
// Assumes: row spans 16 bytes from 0x4800
// Notes: decode relations hold only once the scan is done
`timescale 1ns/1ps
module option_byte_config_decoder_sva (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic in_circuit_programming_i,
  input wire logic link_wr_i,
  input wire logic [15:0] link_addr_i,
  input wire logic cpu_wr_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic cpu_wr_refused_o,
  input wire logic config_valid_o,
  input wire logic [7:0] boot_area_pages_o,
  input wire logic [7:0] boot_vector_pages_o,
  input wire logic [7:0] data_area_pages_o,
  input wire logic [15:0] data_area_base_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // row decode of both write ports
  wire cpu_row = cpu_addr_i[15:4] == 12'h480;
  wire link_row = link_addr_i[15:4] == 12'h480;
  // three samples low clear the two-flop synchroniser
  sequence s_mode_off;
    !in_circuit_programming_i [*3];
  endsequence
  property p_cpu_ref; cpu_wr_i && cpu_row |=> cpu_wr_refused_o; endproperty
  a_cpu_ref: assert property (p_cpu_ref) else $error("cpu row write not refused");
  property p_link_ref; s_mode_off ##0 (link_wr_i && link_row) |=> cpu_wr_refused_o; endproperty
  a_link_ref: assert property (p_link_ref) else $error("link write outside mode not refused");
  property p_boot_top; config_valid_o |-> !boot_area_pages_o[7]; endproperty
  a_boot_top: assert property (p_boot_top) else $error("boot size top bit set");
  property p_data_top; config_valid_o |-> data_area_pages_o[7:6] == 2'b00; endproperty
  a_data_top: assert property (p_data_top) else $error("data size top bits set");
  property p_vect;
    config_valid_o |-> boot_vector_pages_o == (boot_area_pages_o > 8'h02 ? 8'h02 : boot_area_pages_o);
  endproperty
  a_vect: assert property (p_vect) else $error("vector pages wrong");
  property p_base; config_valid_o |-> data_area_base_o == 16'hA000 - {2'b00, data_area_pages_o, 6'h00}; endproperty
  a_base: assert property (p_base) else $error("data area base wrong");
  // the captured view may not drift while valid stands
  property p_hold;
    config_valid_o && $past(config_valid_o) |-> $stable(boot_area_pages_o) && $stable(data_area_base_o);
  endproperty
  a_hold: assert property (p_hold) else $error("decoded config moved");
  property p_scan; !config_valid_o |-> ##[1:30] config_valid_o; endproperty
  a_scan: assert property (p_scan) else $error("scan did not finish");
endmodule
bind option_byte_config_decoder option_byte_config_decoder_sva u_sva (.clk_sys_i, .reset_i,
  .in_circuit_programming_i, .link_wr_i, .link_addr_i, .cpu_wr_i, .cpu_addr_i, .cpu_wr_refused_o,
  .config_valid_o, .boot_area_pages_o, .boot_vector_pages_o, .data_area_pages_o, .data_area_base_o);

// ===== test/option_byte_config_decoder_test.sv
// Purpose: self-checking bench of the option byte decoder
// Assumes: programmer model drives the link port
// Notes: every decode case needs a reset, as capture is once per reset
`timescale 1ns/1ps
module option_byte_config_decoder_test;
  import option_cfg_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic cpu_wr_i = 1'b0;
  logic [15:0] cpu_addr_i = 16'h0000;
  wire in_circuit_programming_i, link_wr_i;
  wire [15:0] link_addr_i;
  wire [7:0] link_wdata_i;
  logic cpu_wr_refused_o, config_valid_o, readout_guard_o, boot_area_protect_o, data_area_present_o;
  logic watchdog_autostart_o, watchdog_lowpower_freeze_o, read_access_unsure_o;
  logic [7:0] boot_area_pages_o, boot_vector_pages_o, data_area_pages_o;
  logic [15:0] data_area_base_o;
  int bad_count = 0;
  int n_checks = 0;
  // guard, boot, data, watchdog, 0x4807 byte
  logic [39:0] cases [5] = '{40'hAA83E00300, 40'h5500000000, 40'h0001010100, 40'h0002020200, 40'hABFF42005A};
  option_link_programmer prog (.clk_sys_i, .mode_o(in_circuit_programming_i), .link_wr_o(link_wr_i),
    .link_addr_o(link_addr_i), .link_wdata_o(link_wdata_i));
  option_byte_config_decoder dut (.clk_sys_i, .reset_i, .in_circuit_programming_i, .link_wr_i, .link_addr_i,
    .link_wdata_i, .cpu_wr_i, .cpu_addr_i, .cpu_wr_refused_o, .config_valid_o, .readout_guard_o,
    .boot_area_pages_o, .boot_area_protect_o, .boot_vector_pages_o, .data_area_pages_o, .data_area_base_o,
    .data_area_present_o, .watchdog_autostart_o, .watchdog_lowpower_freeze_o, .read_access_unsure_o);
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // bounded wait for the scan, since its length is only roughly known
  task automatic do_reset();
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 40 && config_valid_o !== 1'b1; i++) @(posedge clk_sys_i);
    #1 chk(config_valid_o, 1'b1);
  endtask
  // each case: program row, reset, compare all decoded fields
  task automatic t_decode();
    logic [7:0] g, b, d, w, u, eb, ed;
    for (int k = 0; k < 5; k++) begin
      {g, b, d, w, u} = cases[k];
      prog.set_mode(1'b1);
      prog.row(g, b, d, w, u);
      do_reset();
      eb = b & BOOT_AREA_PAGE_MASK;
      ed = d & DATA_AREA_PAGE_MASK;
      chk(readout_guard_o, g == 8'hAA);
      chk(boot_area_pages_o, eb);
      chk(boot_vector_pages_o, eb > 8'h02 ? 8'h02 : eb);
      chk(boot_area_protect_o, eb != 8'h00);
      chk(data_area_pages_o, ed);
      chk(data_area_base_o, 16'hA000 - {2'b00, ed, 6'h00});
      chk(data_area_present_o, ed != 8'h00);
      chk(watchdog_autostart_o, w[0]);
      chk(watchdog_lowpower_freeze_o, w[1]);
      chk(read_access_unsure_o, u != 8'h00);
    end
  endtask
  task automatic cpu_put(input logic [15:0] a, input logic exp);
    @(posedge clk_sys_i);
    cpu_wr_i <= 1'b1;
    cpu_addr_i <= a;
    @(posedge clk_sys_i);
    cpu_wr_i <= 1'b0;
    #1 chk(cpu_wr_refused_o, exp);
  endtask
  // writes outside mode or from the cpu must leave the row alone
  task automatic t_refuse();
    prog.set_mode(1'b0);
    prog.put(READOUT_GUARD_BYTE_ADDR, READOUT_GUARD_ON);
    #1 chk(cpu_wr_refused_o, 1'b1);
    cpu_put(BOOT_AREA_SIZE_BYTE_ADDR, 1'b1);
    cpu_put(16'h5000, 1'b0);
    do_reset();
    chk(readout_guard_o, 1'b0);
    chk(boot_area_pages_o, 8'h7F);
  endtask
  // new bytes show only after the next reset
  task automatic t_hold();
    prog.set_mode(1'b1);
    prog.put(BOOT_AREA_SIZE_BYTE_ADDR, 8'h00);
    repeat (3) @(posedge clk_sys_i);
    chk(boot_area_pages_o, 8'h7F);
    do_reset();
    chk(boot_area_pages_o, 8'h00);
  endtask
  initial begin
    do_reset();
    t_decode();
    t_refuse();
    t_hold();
    end_sim();
  end
  // the run needs well under a thousand cycles
  initial begin
    #20000;
    bad_count++;
    end_sim();
  end
endmodule
